// File: test_video_switch_config_registers.sv
// Testbench for the configuration store
`timescale 1ns/1ps
module test_video_switch_config_registers;
    import vsw_cfg_pkg::*;
    logic clk_i = 0, rst_n_i = 0;
    strap_pins_t want, straps;
    serial_req_t req_i = '0;
    logic [7:0] rd, hs, aux, rs, tl, th, el, eh, tx;
    logic pm;
    analog_ctl_t an;
    lane_eq_t le;
    int errors = 0, check_count = 0, cycles = 0;
    vsw_strap_board board (.clk_i, .rst_n_i, .want_i(want), .straps_o(straps));
    video_switch_config_registers uut (.clk_i, .rst_n_i, .straps_i(straps),
        .req_i, .rd_data_o(rd), .parallel_mode_o(pm),
        .strap_highspeed_modes_o(hs), .strap_auxiliary_modes_o(aux),
        .strap_receiver_settings_o(rs), .strap_input_termination_low_o(tl),
        .strap_input_termination_high_o(th), .strap_rx_equalizer_low_o(el),
        .strap_rx_equalizer_high_o(eh), .strap_transmitter_settings_o(tx),
        .analog_o(an), .lane_eq_o(le));
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    // Hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            finish_test();
        end
    end
    task automatic chk(input logic [35:0] g, input logic [35:0] e);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic do_reset(input strap_pins_t s);
        @(posedge clk_i);
        #1 rst_n_i = 0;
        want = s;
        repeat (16) @(posedge clk_i);
        #1 rst_n_i = 1;
    endtask
    // One serial access, then one idle cycle
    task automatic acc(input logic w, input logic [2:0] i, input logic [7:0] d);
        @(posedge clk_i);
        #1 req_i = {1'b1, w, i, d};
        @(posedge clk_i);
        #1 req_i = '0;
    endtask
    task automatic finish_test();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        logic [1:0] i;
        for (int k = 0; k < 4; k++) begin
            i = 2'(k);
            do_reset({i[0], i, i[1], i, ~i[0], i[1]});
            chk(hs, {1'b0, i[0], 4'h0, i});
            chk(aux, {2'h1, 4'h0, i});
            chk(tx, {4'h0, i, ~i[0], i[1]});
            chk({el, eh}, {16{i[1]}});
            chk({tl, th, rs}, 0);
            chk(an, {{16{i[1]}}, 16'h0, i, ~i[0], i[1]});
            chk(pm, 1);
        end
        acc(0, IDX_TX, 0);
        chk({pm, rd}, {1'b0, 8'h0d});
        acc(1, IDX_EQ_LO, 8'h5a);
        acc(1, IDX_EQ_HI, 8'h8e);
        acc(1, IDX_TX, 8'h0e);
        acc(1, 3'h5, 8'hff);
        chk(an, {16'h8e5a, 16'h0, 2'h3, 1'b1, 1'b0});
        chk(le, 16'h5a71);
        acc(0, 3'h5, 0);
        chk(rd, 0);
        acc(0, IDX_EQ_LO, 0);
        chk(rd, 8'h5a);
        do_reset(8'h10);
        chk({pm, an.input_eq_level_bits}, {1'b1, 16'hffff});
        finish_test();
    end
endmodule

// File: video_switch_config_registers.sv
// Configuration store with strap mode and serial override
`timescale 1ns/1ps
module video_switch_config_registers (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire vsw_cfg_pkg::strap_pins_t straps_i,
    input wire vsw_cfg_pkg::serial_req_t req_i,
    output logic [7:0] rd_data_o,
    output logic parallel_mode_o,
    output logic [7:0] strap_highspeed_modes_o,
    output logic [7:0] strap_auxiliary_modes_o,
    output logic [7:0] strap_receiver_settings_o,
    output logic [7:0] strap_input_termination_low_o,
    output logic [7:0] strap_input_termination_high_o,
    output logic [7:0] strap_rx_equalizer_low_o,
    output logic [7:0] strap_rx_equalizer_high_o,
    output logic [7:0] strap_transmitter_settings_o,
    output vsw_cfg_pkg::analog_ctl_t analog_o,
    output vsw_cfg_pkg::lane_eq_t lane_eq_o
);
    import vsw_cfg_pkg::*;

    logic parallel_r; // High until first serial access
    logic [1:0] sel_r; // Source select caught in reset
    logic [7:0] eq_lo_r; // Serial equalizer low byte
    logic [7:0] eq_hi_r; // Serial equalizer high byte
    logic [7:0] tx_r; // Serial transmitter settings
    logic [15:0] eq_all; // Active 16 equalizer bits
    logic [7:0] tx_act; // Active transmitter byte
    logic [7:0] rd_nxt;

    // Mode flag: any serial access leaves strap mode until reset
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            parallel_r <= 1'b1;
        end else if (req_i.access) begin
            parallel_r <= 1'b0;
        end
    end

    // Select straps: tracked only while reset holds; relies on it
    // Synchronous sampling, since async reset may load constants only
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sel_r <= straps_i.strap_source_select;
        end
    end

    // Serial writes; the first access also loads straps as a base
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            eq_lo_r <= ZERO_BYTE;
            eq_hi_r <= ZERO_BYTE;
            tx_r <= ZERO_BYTE;
        end else begin
            if (parallel_r && req_i.access) begin
                // Carry strap values so a read-only access changes nothing
                eq_lo_r <= {8{straps_i.strap_eq_level}};
                eq_hi_r <= {8{straps_i.strap_eq_level}};
                tx_r <= tx_act;
            end
            if (req_i.access && req_i.wr) begin
                if (req_i.idx == IDX_EQ_LO) begin
                    eq_lo_r <= req_i.data;
                end else if (req_i.idx == IDX_EQ_HI) begin
                    eq_hi_r <= req_i.data;
                end else if (req_i.idx == IDX_TX) begin
                    tx_r <= req_i.data;
                end
            end
        end
    end

    // Strap register images
    always_comb begin
        strap_highspeed_modes_o = ZERO_BYTE;
        strap_highspeed_modes_o[HS_EN_BIT] =
            straps_i.strap_highspeed_enable;
        strap_highspeed_modes_o[SEL_LSB +: 2] = sel_r;
        strap_auxiliary_modes_o = ZERO_BYTE;
        strap_auxiliary_modes_o[HS_EN_BIT] = AUX_FORCED_ON;
        strap_auxiliary_modes_o[SEL_LSB +: 2] = sel_r;
        strap_receiver_settings_o = ZERO_BYTE;
        strap_input_termination_low_o = ZERO_BYTE;
        strap_input_termination_high_o = ZERO_BYTE;
        strap_rx_equalizer_low_o = {8{straps_i.strap_eq_level}};
        strap_rx_equalizer_high_o = {8{straps_i.strap_eq_level}};
        strap_transmitter_settings_o = ZERO_BYTE;
        strap_transmitter_settings_o[OUTPUT_PREEMPH_FIELD_LSB +: 2] =
            straps_i.strap_preemph_pins;
        strap_transmitter_settings_o[TX_TERM_BIT] =
            straps_i.strap_output_term;
        strap_transmitter_settings_o[TX_CUR_BIT] =
            straps_i.strap_output_current;
    end

    // Active source: straps in parallel mode, serial values after
    always_comb begin
        if (parallel_r) begin
            eq_all = {strap_rx_equalizer_high_o, strap_rx_equalizer_low_o};
            tx_act = strap_transmitter_settings_o;
        end else begin
            eq_all = {eq_hi_r, eq_lo_r};
            tx_act = tx_r;
        end
    end

    // Analog controls; termination select registers live elsewhere
    always_comb begin
        analog_o.input_eq_level_bits = eq_all;
        analog_o.input_term_bits = 16'h0000;
        analog_o.output_preemph_field =
            preemph_t'(tx_act[OUTPUT_PREEMPH_FIELD_LSB +: 2]);
        analog_o.output_term_enable = tx_act[TX_TERM_BIT];
        analog_o.output_current_select = tx_act[TX_CUR_BIT];
    end

    // Lane map: B plain, A plain, C and D reversed
    always_comb begin
        lane_eq_o.src_b = eq_all[3:0];
        lane_eq_o.src_a = eq_all[7:4];
        lane_eq_o.src_c = {eq_all[8], eq_all[9], eq_all[10], eq_all[11]};
        lane_eq_o.src_d = {eq_all[12], eq_all[13], eq_all[14], eq_all[15]};
    end

    // Read mux, registered for a clean data output
    always_comb begin
        if (req_i.idx == IDX_EQ_LO) begin
            rd_nxt = eq_all[7:0];
        end else if (req_i.idx == IDX_EQ_HI) begin
            rd_nxt = eq_all[15:8];
        end else if (req_i.idx == IDX_TX) begin
            rd_nxt = tx_act;
        end else begin
            rd_nxt = ZERO_BYTE; // Unmapped index reads zero
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_o <= ZERO_BYTE;
        end else if (req_i.access && !req_i.wr) begin
            rd_data_o <= rd_nxt;
        end
    end

    assign parallel_mode_o = parallel_r;

endmodule

// File: vsw_cfg_assertions.sv
// Checker for the video switch configuration store
`timescale 1ns/1ps
module vsw_cfg_assertions
    import vsw_cfg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire strap_pins_t straps_i,
    input wire serial_req_t req_i,
    input wire logic [7:0] rd_data_o,
    input wire logic parallel_mode_o,
    input wire logic [7:0] strap_highspeed_modes_o,
    input wire logic [7:0] strap_auxiliary_modes_o,
    input wire logic [7:0] strap_transmitter_settings_o,
    input wire analog_ctl_t analog_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Serial write to one index
    sequence s_wr(i);
        req_i.access && req_i.wr && req_i.idx == i;
    endsequence
    a_mode_ends: assert property (req_i.access |=> !parallel_mode_o)
        else $error("strap mode kept after access");
    a_mode_holds: assert property (parallel_mode_o && !req_i.access
        |=> parallel_mode_o) else $error("strap mode lost");
    a_hs_image: assert property (strap_highspeed_modes_o[7:2] ==
        {1'b0, straps_i.strap_highspeed_enable, 4'h0})
        else $error("mode image wrong");
    a_aux_forced: assert property (strap_auxiliary_modes_o ==
        {2'h1, 4'h0, strap_highspeed_modes_o[1:0]})
        else $error("aux image wrong");
    a_sel_frozen: assert property (1 |=> $stable(strap_highspeed_modes_o[1:0]))
        else $error("select moved while running");
    a_eq_copy: assert property (parallel_mode_o |->
        analog_o.input_eq_level_bits == {16{straps_i.strap_eq_level}})
        else $error("eq not from strap");
    a_term_open: assert property (analog_o.input_term_bits == 16'h0)
        else $error("input termination closed");
    a_wr_eq: assert property (s_wr(IDX_EQ_HI) |=>
        analog_o.input_eq_level_bits[15:8] == $past(req_i.data))
        else $error("eq write lost");
    a_read_tx: assert property (req_i.access && !req_i.wr && parallel_mode_o
        && req_i.idx == IDX_TX |=> rd_data_o ==
        $past(strap_transmitter_settings_o))
        else $error("first read not strap value");
endmodule
bind video_switch_config_registers vsw_cfg_assertions chk (.clk_i, .rst_n_i,
    .straps_i, .req_i, .rd_data_o, .parallel_mode_o, .strap_highspeed_modes_o,
    .strap_auxiliary_modes_o, .strap_transmitter_settings_o, .analog_o);

// File: vsw_cfg_pkg.sv
// Package: constants and types for the video switch configuration store
// Operation
// - Equalization bit: clear 6 dB, set 12 dB
// - Sixteen equalization bits map B, A, C reversed, D reversed
// - Two-bit pre-emphasis: 0, 2, 4, 6 dB
// - One bit connects all output terminations
// - One bit selects 10 or 20 mA
// - Straps rule only from reset to serial access
// - Enable strap low puts channels in standby
// - Select straps route sources A to D
// - Select straps also route auxiliary, enable forced
// - Parallel mode keeps input terminations all open
// - All equalizer bits copy the single strap
// - Transmitter register takes pre-emphasis, termination, current
// - Modes register: enable bit 6, select bits 1:0
package vsw_cfg_pkg;

    // Field positions
    localparam int TX_CUR_BIT = 0; // Output current select
    localparam int TX_TERM_BIT = 1; // Output termination
    localparam int OUTPUT_PREEMPH_FIELD_LSB = 2; // Pre-emphasis low bit
    localparam int HS_EN_BIT = 6; // Enable bit in mode registers
    localparam int SEL_LSB = 0; // Source select low bit

    // Values after reset and fixed fields
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [1:0] SEL_RESET = 2'h0;
    localparam logic AUX_FORCED_ON = 1'b1;

    // Serial register indices, local to this store
    localparam logic [2:0] IDX_EQ_LO = 3'h0;
    localparam logic [2:0] IDX_EQ_HI = 3'h1;
    localparam logic [2:0] IDX_TX = 3'h2;

    // Decoded analog controls for the high speed path
    typedef enum logic [1:0] {
        PE_0DB,
        PE_2DB,
        PE_4DB,
        PE_6DB
    } preemph_t;

    typedef struct packed {
        logic [15:0] input_eq_level_bits; // 1 = 12 dB, 0 = 6 dB
        logic [15:0] input_term_bits; // 1 = termination connected
        preemph_t output_preemph_field; // For all outputs
        logic output_term_enable; // 1 = terminations connected
        logic output_current_select; // 1 = 20 mA, 0 = 10 mA
    } analog_ctl_t;

    // Per-source lane view of the equalizer bits
    typedef struct packed {
        logic [3:0] src_a; // Lanes 3..0
        logic [3:0] src_b;
        logic [3:0] src_c;
        logic [3:0] src_d;
    } lane_eq_t;

    // Strap pins, all fixed levels on the board
    typedef struct packed {
        logic strap_highspeed_enable;
        logic [1:0] strap_source_select;
        logic strap_eq_level;
        logic [1:0] strap_preemph_pins;
        logic strap_output_term;
        logic strap_output_current;
    } strap_pins_t;

    // Serial register access port, reads and writes
    typedef struct packed {
        logic access; // Any serial access, read or write
        logic wr; // Write strobe
        logic [2:0] idx; // Register index
        logic [7:0] data; // Write data
    } serial_req_t;

endpackage

// File: vsw_strap_board.sv
// Board strap model: fixed ties, changed only under reset
`timescale 1ns/1ps
module vsw_strap_board
    import vsw_cfg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire strap_pins_t want_i,
    output strap_pins_t straps_o
);
    // Re-strapping happens only while reset is held
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            straps_o <= want_i;
        end
    end
endmodule
